/* File: gateway_map.vh */
/*
 holds offsets, field positions, reset values and timing counts of the gateway status/routing block.
 assumes a 40 MHz core clock and a classic wishbone slave with 32-bit data.
*/
`ifndef GATEWAY_MAP_VH
`define GATEWAY_MAP_VH
`define CLK_HZ 40000000
`define BLINK_PERIOD_MS 1000
`define BLINK_HALF_CYC ((`CLK_HZ / 1000) * `BLINK_PERIOD_MS / 2)
`define SELFTEST_STEP_MS 500
`define SELFTEST_STEP_CYC ((`CLK_HZ / 1000) * `SELFTEST_STEP_MS)
`define SERVICE_BAUD 9600
`define BAUD_DIV (`CLK_HZ / `SERVICE_BAUD)
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_IRQ_STAT 8'h08
`define ADR_IRQ_MASK 8'h0c
`define ADR_SVC_TX 8'h10
`define ADR_SVC_RX 8'h14
`define CTRL_BOOT 0
`define CTRL_BOARD_ERR 1
`define CTRL_NET_OK 2
`define CTRL_CONN 3
`define CTRL_NET_ERR 4
`define CTRL_CONN_TMO 5
`define CTRL_DEV_ERR 6
`define CTRL_RST 8'h00
`define IRQ_RX 0
`define IRQ_TX_DONE 1
`define IRQ_SEL_CHG 2
`define IRQ_SELFTEST 3
`define SEL_RUN 2'h0
`define SEL_DEVICE 2'h1
`define SEL_GATEWAY 2'h2
`define CHAR_STX 8'h02
`define CHAR_CR 8'h0d
`define CHAR_LF 8'h0a
`define LED_OFF 2'h0
`define LED_GREEN 2'h1
`define LED_RED 2'h2
`define LED_ORANGE 2'h3
`endif

/* File: blink_divider.v */
/*
 holds the common flash divider: a ~1 s square wave and a self-test step pulse.
 assumes one clock and a synchronous active-high reset.
*/
`include "gateway_map.vh"
module blink_divider (
    input wire clk,
    input wire rst,
    output reg blink_q,
    output reg step_q
);
    reg [24:0] half_cnt_q;
    reg [24:0] step_cnt_q;

    always @(posedge clk) begin
        if (rst) begin
            half_cnt_q <= 25'h0;
            step_cnt_q <= 25'h0;
            blink_q <= 1'b0;
            step_q <= 1'b0;
        end else begin
            step_q <= 1'b0;
            if (half_cnt_q == `BLINK_HALF_CYC - 1) begin
                half_cnt_q <= 25'h0;
                blink_q <= ~blink_q;
            end else begin
                half_cnt_q <= half_cnt_q + 25'h1;
            end
            if (step_cnt_q == `SELFTEST_STEP_CYC - 1) begin
                step_cnt_q <= 25'h0;
                step_q <= 1'b1;
            end else begin
                step_cnt_q <= step_cnt_q + 25'h1;
            end
        end
    end
endmodule // blink_divider

/* File: service_uart.v */
/*
 holds the service port serial engine: rxd/txd only, 8 data bits, no parity, 1 stop bit.
 assumes rxd is synchronous to the clock and idles high.
*/
`include "gateway_map.vh"
module service_uart (
    input wire clk,
    input wire rst,
    input wire rxd,
    output reg txd_q,
    input wire tx_start,
    input wire [7:0] tx_data,
    output wire tx_busy,
    output reg [7:0] rx_data_q,
    output reg rx_valid_q
);
    reg [12:0] tx_cnt_q;
    reg [3:0] tx_bit_q;
    reg [8:0] tx_sh_q;
    reg tx_act_q;
    reg [12:0] rx_cnt_q;
    reg [3:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg rx_act_q;

    assign tx_busy = tx_act_q;

    // no rts/cts: flow control is left to the pc
    always @(posedge clk) begin
        if (rst) begin
            txd_q <= 1'b1;
            tx_act_q <= 1'b0;
            tx_cnt_q <= 13'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 9'h1ff;
        end else if (!tx_act_q) begin
            if (tx_start) begin
                tx_act_q <= 1'b1;
                txd_q <= 1'b0;
                tx_sh_q <= {1'b1, tx_data}; // 8n1
                tx_cnt_q <= 13'h0;
                tx_bit_q <= 4'h0;
            end
        end else if (tx_cnt_q == `BAUD_DIV - 1) begin
            tx_cnt_q <= 13'h0;
            if (tx_bit_q == 4'h9) begin
                tx_act_q <= 1'b0;
            end else begin
                txd_q <= tx_sh_q[0];
                tx_sh_q <= {1'b1, tx_sh_q[8:1]};
                tx_bit_q <= tx_bit_q + 4'h1;
            end
        end else begin
            tx_cnt_q <= tx_cnt_q + 13'h1;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rx_act_q <= 1'b0;
            rx_cnt_q <= 13'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (!rx_act_q) begin
                if (!rxd) begin
                    rx_act_q <= 1'b1;
                    rx_cnt_q <= 13'h0;
                    rx_bit_q <= 4'h0;
                end
            end else if ((rx_bit_q == 4'h0 && rx_cnt_q == `BAUD_DIV / 2 - 1) ||
                         (rx_bit_q != 4'h0 && rx_cnt_q == `BAUD_DIV - 1)) begin
                rx_cnt_q <= 13'h0;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0 && rxd) begin
                    rx_act_q <= 1'b0; // glitch, not a start bit
                end else if (rx_bit_q == 4'h9) begin
                    rx_act_q <= 1'b0;
                    if (rxd) begin
                        rx_data_q <= rx_sh_q;
                        rx_valid_q <= 1'b1;
                    end
                end else if (rx_bit_q != 4'h0) begin
                    rx_sh_q <= {rxd, rx_sh_q[7:1]};
                end
            end else begin
                rx_cnt_q <= rx_cnt_q + 13'h1;
            end
        end
    end
endmodule // service_uart

/* File: gateway_status_and_service_routing.v */
/*
 holds the gateway status/routing top: service-port routing, fieldbus/end-device path gating,
 the gateway's own service serial engine, led encoders and a wishbone register file.
 assumes the fieldbus stack, end-device uart and selector switch are outside and synchronous.
*/
// The register addresses and the Wishbone register port were left to the implementer.
`include "gateway_map.vh"
module gateway_status_and_service_routing (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output wire WB_ERR_O,
    output wire IRQ_O,
    input wire [1:0] SERVICE_SELECT,
    input wire SVC_RXD,
    output wire SVC_TXD,
    input wire DEV_RXD,
    output wire DEV_TXD,
    input wire FB_TXD,
    output wire FB_RXD,
    output wire FB_NODE_ENABLE,
    output wire [1:0] BOARD_LED,
    output wire [1:0] NETWORK_STATUS_LED,
    output wire [1:0] POWER_LED
);
    localparam ST_TEST_RED = 4'b0001;
    localparam ST_TEST_GREEN = 4'b0010;
    localparam ST_TEST_OFF = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg [7:0] ctrl_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg [3:0] test_q;
    reg [1:0] sel_prev_q;
    reg [7:0] tx_data_q;
    reg tx_start_q;
    reg [7:0] rx_hold_q;
    reg rx_full_q;
    reg [1:0] board_led_q;
    reg [1:0] net_led_q;
    reg [1:0] pwr_led_q;
    wire blink;
    wire step;
    wire gw_txd;
    wire tx_busy;
    wire [7:0] rx_data;
    wire rx_valid;
    wire sel_dev;
    wire sel_gw;
    wire in_service;
    wire bus_req;
    wire rd_irq_stat;
    wire rd_rx;
    wire tx_done;
    reg tx_busy_q;
    reg [3:0] irq_set;
    reg [1:0] board_led_d;
    reg [1:0] net_led_d;
    reg [1:0] pwr_led_d;
    reg [31:0] rd_data_d;

    function [1:0] sel_decode;
        input [1:0] pos;
        begin
            case (pos)
                `SEL_DEVICE: sel_decode = 2'b01;
                `SEL_GATEWAY: sel_decode = 2'b10;
                default: sel_decode = 2'b00;
            endcase
        end
    endfunction

    // self-test colour of a step; both leds run off one sequencer
    function [1:0] test_colour;
        input [3:0] state;
        begin
            case (state)
                ST_TEST_RED: test_colour = `LED_RED;
                ST_TEST_GREEN: test_colour = `LED_GREEN;
                default: test_colour = `LED_OFF;
            endcase
        end
    endfunction

    // all flashing leds share the divider phase, so they blink in step
    function [1:0] flash_colour;
        input phase;
        input [1:0] lit;
        input [1:0] dark;
        begin
            flash_colour = phase ? lit : dark;
        end
    endfunction

    // accepted read of one register; clear-on-read side effects hang off it
    function rd_hit;
        input req;
        input we;
        input [7:0] adr;
        input [7:0] target;
        begin
            rd_hit = req & ~we & (adr == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // divider and serial engine

    blink_divider u_blink (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .blink_q(blink),
        .step_q(step)
    );

    service_uart u_uart (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .rxd(sel_gw ? SVC_RXD : 1'b1),
        .txd_q(gw_txd),
        .tx_start(tx_start_q),
        .tx_data(tx_data_q),
        .tx_busy(tx_busy),
        .rx_data_q(rx_data),
        .rx_valid_q(rx_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // routing

    // a reserved code falls back to run, the safe position
    assign sel_dev = sel_decode(SERVICE_SELECT) == 2'b01;
    assign sel_gw = sel_decode(SERVICE_SELECT) == 2'b10;
    assign in_service = sel_dev | sel_gw;

    assign SVC_TXD = sel_dev ? DEV_RXD : (sel_gw ? gw_txd : 1'b1);
    assign DEV_TXD = sel_dev ? SVC_RXD : (in_service ? 1'b1 : FB_TXD);
    assign FB_RXD = in_service ? 1'b1 : DEV_RXD;
    // node never gated by service; only the self-test holds it back
    assign FB_NODE_ENABLE = test_q == ST_DONE;

    ////////////////////////////////////////////////////////////////////////////
    // power-up self-test sequence

    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            test_q <= ST_TEST_RED;
        end else if (step) begin
            case (test_q)
                ST_TEST_RED: test_q <= ST_TEST_GREEN;
                ST_TEST_GREEN: test_q <= ST_TEST_OFF;
                ST_TEST_OFF: test_q <= ST_DONE;
                ST_DONE: test_q <= ST_DONE;
                default: test_q <= ST_TEST_RED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // led encoders

    always @* begin
        if (ctrl_q[`CTRL_BOOT])
            board_led_d = flash_colour(blink, `LED_GREEN, `LED_ORANGE);
        else if (ctrl_q[`CTRL_BOARD_ERR])
            board_led_d = `LED_ORANGE;
        else if (ctrl_q[`CTRL_DEV_ERR])
            board_led_d = `LED_OFF;
        else
            board_led_d = `LED_GREEN;
    end

    always @* begin
        if (test_q != ST_DONE) begin
            net_led_d = test_colour(test_q);
            pwr_led_d = test_colour(test_q);
        end else begin
            pwr_led_d = ctrl_q[`CTRL_DEV_ERR] ? `LED_OFF : `LED_GREEN;
            // errors outrank the healthy states
            if (ctrl_q[`CTRL_NET_ERR])
                net_led_d = `LED_RED;
            else if (ctrl_q[`CTRL_CONN_TMO])
                net_led_d = flash_colour(blink, `LED_RED, `LED_OFF);
            else if (ctrl_q[`CTRL_NET_OK] && ctrl_q[`CTRL_CONN])
                net_led_d = `LED_GREEN;
            else if (ctrl_q[`CTRL_NET_OK])
                net_led_d = flash_colour(blink, `LED_GREEN, `LED_OFF);
            else
                net_led_d = `LED_OFF;
        end
    end

    // registered so the pins never glitch between two encodings
    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            board_led_q <= `LED_OFF;
            net_led_q <= `LED_OFF;
            pwr_led_q <= `LED_OFF;
        end else begin
            board_led_q <= board_led_d;
            net_led_q <= net_led_d;
            pwr_led_q <= pwr_led_d;
        end
    end

    assign BOARD_LED = board_led_q;
    assign NETWORK_STATUS_LED = net_led_q;
    assign POWER_LED = pwr_led_q;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave, one wait-free cycle then ack

    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign WB_ERR_O = 1'b0;
    assign rd_irq_stat = rd_hit(bus_req, WB_WE_I, WB_ADR_I, `ADR_IRQ_STAT);
    assign rd_rx = rd_hit(bus_req, WB_WE_I, WB_ADR_I, `ADR_SVC_RX);
    assign tx_done = tx_busy_q & ~tx_busy;
    assign IRQ_O = |(irq_stat_q & irq_mask_q);

    always @* begin
        irq_set = 4'h0;
        irq_set[`IRQ_RX] = rx_valid;
        irq_set[`IRQ_TX_DONE] = tx_done;
        irq_set[`IRQ_SEL_CHG] = SERVICE_SELECT != sel_prev_q;
        irq_set[`IRQ_SELFTEST] = step & (test_q == ST_TEST_OFF);
    end

    // read mux; the clocked side only latches it on an accepted read
    always @* begin
        case (WB_ADR_I)
            `ADR_CTRL: rd_data_d = {24'h0, ctrl_q};
            `ADR_STATUS: rd_data_d = {22'h0, tx_busy, rx_full_q, test_q, in_service, sel_gw, sel_dev,
                                      FB_NODE_ENABLE};
            `ADR_IRQ_STAT: rd_data_d = {28'h0, irq_stat_q};
            `ADR_IRQ_MASK: rd_data_d = {28'h0, irq_mask_q};
            `ADR_SVC_RX: rd_data_d = {23'h0, rx_full_q, rx_hold_q};
            default: rd_data_d = 32'h0;
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
            ctrl_q <= `CTRL_RST;
            irq_mask_q <= 4'h0;
            irq_stat_q <= 4'h0;
            sel_prev_q <= `SEL_RUN;
            tx_data_q <= 8'h00;
            tx_start_q <= 1'b0;
            tx_busy_q <= 1'b0;
            rx_hold_q <= 8'h00;
            rx_full_q <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req;
            tx_start_q <= 1'b0;
            tx_busy_q <= tx_busy;
            sel_prev_q <= SERVICE_SELECT;
            // a new event outranks the clear-on-read
            irq_stat_q <= (rd_irq_stat ? 4'h0 : irq_stat_q) | irq_set;
            if (rx_valid) begin
                rx_hold_q <= rx_data;
                rx_full_q <= 1'b1;
            end else if (rd_rx) begin
                rx_full_q <= 1'b0;
            end
            if (bus_req && WB_WE_I && WB_SEL_I[0]) begin
                case (WB_ADR_I)
                    `ADR_CTRL: ctrl_q <= WB_DAT_I[7:0];
                    `ADR_IRQ_MASK: irq_mask_q <= WB_DAT_I[3:0];
                    `ADR_SVC_TX: begin
                        // byte dropped while a character is on the line
                        if (!tx_busy && sel_gw) begin
                            tx_data_q <= WB_DAT_I[7:0];
                            tx_start_q <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            if (bus_req && !WB_WE_I) begin
                WB_DAT_O <= rd_data_d;
            end
        end
    end
endmodule // gateway_status_and_service_routing

/* File: gateway_routing_checker.sv */
/* assertions on the gateway status/routing top: path switching, wishbone answer, led colours.
 assumes it is bound to the top module and sees only its ports. */
`include "gateway_map.vh"
module gateway_routing_checker (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire WB_ERR_O,
    input wire [1:0] SERVICE_SELECT,
    input wire SVC_RXD,
    input wire SVC_TXD,
    input wire DEV_RXD,
    input wire DEV_TXD,
    input wire FB_TXD,
    input wire FB_RXD,
    input wire FB_NODE_ENABLE,
    input wire [1:0] NETWORK_STATUS_LED,
    input wire [1:0] POWER_LED
);
////////////////////////////////////////
default clocking cb @(posedge CORE_CLK);
endclocking
default disable iff (SYS_RST);
sequence released;
    $fell(SYS_RST);
endsequence
sequence both_red;
    NETWORK_STATUS_LED == `LED_RED && POWER_LED == `LED_RED;
endsequence
////////////////////////////////////////
ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered in the next cycle");
err_quiet_a: assert property (!WB_ERR_O)
    else $error("error response raised");
run_path_a: assert property (SERVICE_SELECT == 2'h0 || SERVICE_SELECT == 2'h3 |->
    DEV_TXD == FB_TXD && FB_RXD == DEV_RXD && SVC_TXD) else $error("run path not wired through");
dev_route_a: assert property (SERVICE_SELECT == `SEL_DEVICE |->
    SVC_TXD == DEV_RXD && DEV_TXD == SVC_RXD && FB_RXD) else $error("end-device service route wrong");
gw_route_a: assert property (SERVICE_SELECT == `SEL_GATEWAY |-> DEV_TXD && FB_RXD)
    else $error("fieldbus path not cut in gateway service");
node_kept_a: assert property (FB_NODE_ENABLE |=> FB_NODE_ENABLE)
    else $error("fieldbus node dropped");
selftest_red_a: assert property (released |-> ##[0:2] both_red)
    else $error("self-test does not open with red");
selftest_pair_a: assert property (!FB_NODE_ENABLE |-> NETWORK_STATUS_LED == POWER_LED)
    else $error("network and power leds out of step in self-test");
net_colour_a: assert property (NETWORK_STATUS_LED != `LED_ORANGE)
    else $error("network led shows orange");
pwr_ok_a: assert property (FB_NODE_ENABLE |-> POWER_LED == `LED_GREEN || POWER_LED == `LED_OFF)
    else $error("power led colour wrong after self-test");
endmodule // gateway_routing_checker

bind gateway_status_and_service_routing gateway_routing_checker gateway_routing_checker_i (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .WB_ERR_O(WB_ERR_O), .SERVICE_SELECT(SERVICE_SELECT), .SVC_RXD(SVC_RXD), .SVC_TXD(SVC_TXD),
    .DEV_RXD(DEV_RXD), .DEV_TXD(DEV_TXD), .FB_TXD(FB_TXD), .FB_RXD(FB_RXD), .FB_NODE_ENABLE(FB_NODE_ENABLE),
    .NETWORK_STATUS_LED(NETWORK_STATUS_LED), .POWER_LED(POWER_LED));

/* File: service_pc_model.sv */
/* service terminal model: sends and receives single 8N1 characters at the header's bit time.
 assumes the core clock is fed in; the line idles high between characters. */
`include "gateway_map.vh"
module service_pc_model (
    input wire logic clk,
    input wire logic rxd,
    output logic txd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial txd = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0}; // start, data lsb first, one stop, no parity
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            txd <= frame[i];
            repeat (`BAUD_DIV - 1) @(posedge clk);
        end
    endtask
    task automatic recv(output logic [7:0] b, output logic stop_ok);
        while (rxd !== 1'b0) @(posedge clk);
        repeat (`BAUD_DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (`BAUD_DIV) @(posedge clk);
            b[i] = rxd;
        end
        repeat (`BAUD_DIV) @(posedge clk);
        stop_ok = rxd; // no rts/cts, so framing is the only guard
    endtask
endmodule // service_pc_model

/* File: gateway_status_and_service_routing_tb_top.sv */
/* self-checking bench: reset state, service serial traffic, routing per selector, interrupt.
 assumes the 40 MHz clock and the header's full self-test length, so leds stay in self-test. */
`include "gateway_map.vh"
module gateway_status_and_service_routing_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, sys_rst, cyc, stb, we, ack, err, irq, rxd_tb, dev_rxd, fb_txd;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    logic [1:0] svc_sel, board_led, net_led, pwr_led;
    wire svc_rxd, svc_txd, dev_txd, fb_rxd, node_en, pc_txd;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    assign svc_rxd = pc_txd & rxd_tb;
    gateway_status_and_service_routing gateway_status_and_service_routing_i (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .WB_ERR_O(err), .IRQ_O(irq),
        .SERVICE_SELECT(svc_sel), .SVC_RXD(svc_rxd), .SVC_TXD(svc_txd), .DEV_RXD(dev_rxd), .DEV_TXD(dev_txd),
        .FB_TXD(fb_txd), .FB_RXD(fb_rxd), .FB_NODE_ENABLE(node_en), .BOARD_LED(board_led),
        .NETWORK_STATUS_LED(net_led), .POWER_LED(pwr_led));
    service_pc_model service_pc_model_i (.clk(core_clk), .rxd(svc_txd), .txd(pc_txd));
////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one classic cycle; the bench timeout bounds the wait for ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat_w <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
////////////////////////////////////////
    task t_reset;
        logic [31:0] d;
        @(posedge core_clk);
        #1;
        check({30'h0, net_led}, {30'h0, `LED_RED});
        check({30'h0, pwr_led}, {30'h0, `LED_RED});
        check({31'h0, irq}, 32'h0);
        wb(1'b0, `ADR_CTRL, 32'h0, d);
        check(d, 32'h0);
        wb(1'b0, `ADR_IRQ_MASK, 32'h0, d);
        check(d, 32'h0);
        wb(1'b0, `ADR_STATUS, 32'h0, d);
        check(d & 32'h3ff, 32'h010);
        wb(1'b1, 8'h1c, 32'hffffffff, d);
        wb(1'b0, 8'h1c, 32'h0, d);
        check(d, 32'h0);
        wb(1'b1, `ADR_CTRL, 32'h7f, d);
        wb(1'b0, `ADR_CTRL, 32'h0, d);
        check(d, 32'h7f);
        check({30'h0, board_led}, {30'h0, `LED_ORANGE});
        wb(1'b1, `ADR_CTRL, 32'h40, d);
        #1;
        check({30'h0, board_led}, {30'h0, `LED_OFF});
        wb(1'b1, `ADR_CTRL, 32'h02, d);
        #1;
        check({30'h0, board_led}, {30'h0, `LED_ORANGE});
        wb(1'b1, `ADR_CTRL, 32'h00, d);
        #1;
        check({30'h0, board_led}, {30'h0, `LED_GREEN});
    endtask
    task t_serial;
        logic [31:0] d;
        logic [7:0] got;
        logic ok;
        svc_sel <= `SEL_GATEWAY;
        wb(1'b1, `ADR_IRQ_MASK, 32'h3, d);
        fork
            wb(1'b1, `ADR_SVC_TX, {24'h0, `CHAR_STX}, d);
            service_pc_model_i.send(`CHAR_CR);
            service_pc_model_i.recv(got, ok);
        join
        check({24'h0, got}, {24'h0, `CHAR_STX});
        check({31'h0, ok}, 32'h1);
        repeat (`BAUD_DIV) @(posedge core_clk);
        #1;
        check({31'h0, irq}, 32'h1);
        wb(1'b0, `ADR_SVC_RX, 32'h0, d);
        check({23'h0, d[8:0]}, {24'h1, `CHAR_CR});
        wb(1'b0, `ADR_IRQ_STAT, 32'h0, d);
        check(d & 32'h3, 32'h3);
        @(posedge core_clk);
        #1;
        check({31'h0, irq}, 32'h0);
    endtask
    task t_routing;
        logic [31:0] d;
        logic [2:0] exp;
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 2; b++) begin
                svc_sel <= s[1:0];
                rxd_tb <= b[0];
                dev_rxd <= ~b[0];
                fb_txd <= b[0];
                @(posedge core_clk);
                #1;
                case (s)
                    1: exp = {~b[0], b[0], 1'b1};
                    2: exp = 3'b111;
                    default: exp = {1'b1, b[0], ~b[0]};
                endcase
                check({29'h0, svc_txd, dev_txd, fb_rxd}, {29'h0, exp});
            end
            wb(1'b0, `ADR_STATUS, 32'h0, d);
            check({28'h0, d[3:0]}, {28'h0, s == 1 || s == 2, s == 2, s == 1, 1'b0});
            check({31'h0, node_en}, 32'h0);
        end
        rxd_tb <= 1'b1;
        #1;
        check({31'h0, irq}, 32'h0);
        wb(1'b1, `ADR_IRQ_MASK, 32'h4, d);
        @(posedge core_clk);
        #1;
        check({31'h0, irq}, 32'h1);
        wb(1'b0, `ADR_IRQ_STAT, 32'h0, d);
        check({31'h0, d[2]}, 32'h1);
        @(posedge core_clk);
        #1;
        check({31'h0, irq}, 32'h0);
    endtask
////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // one byte takes about 42k cycles each way, run in parallel
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial begin
        {sys_rst, cyc, stb, we, adr, sel, dat_w} = {3'b100, 1'b0, 8'h00, 4'h0, 32'h0};
        {svc_sel, rxd_tb, dev_rxd, fb_txd} = {`SEL_RUN, 3'b111};
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_serial;
        t_routing;
        tally_and_finish;
    end
endmodule // gateway_status_and_service_routing_tb_top
